// ==== core/ic_consts.vh ====
`ifndef IC_CONSTS_VH
`define IC_CONSTS_VH

// i/o window decode: address bits 15..5 pick a controller
`define IC_PRI_BLOCK      11'h001
`define IC_SEC_BLOCK      11'h005
`define IC_PRI_EVEN_PORT  16'h0020
`define IC_PRI_ODD_PORT   16'h0021
`define IC_SEC_EVEN_PORT  16'h00a0
`define IC_SEC_ODD_PORT   16'h00a1

// command word field positions
`define IC_INIT_BIT       4
`define IC_MASK_POLL_READSEL_COMMAND_BIT       3
`define IC_LTIM_BIT       3
`define IC_SNGL_BIT       1
`define IC_IC4_BIT        0
`define IC_AUTO_END_OF_INTERRUPT_BIT       1
`define IC_SPECIAL_MASK_WRITE_ENABLE_BIT       6
`define IC_SMM_BIT        5
`define IC_POLL_BIT       2
`define IC_RR_BIT         1
`define IC_RIS_BIT        0

// rotate/end_of_interrupt command codes, bits 7..5
`define IC_CMD_ROT_CLR    3'h0
`define IC_CMD_NS_EOI     3'h1
`define IC_CMD_NOP        3'h2
`define IC_CMD_S_EOI      3'h3
`define IC_CMD_ROT_SET    3'h4
`define IC_CMD_ROT_NS_EOI 3'h5
`define IC_CMD_SET_PRI    3'h6
`define IC_CMD_ROT_S_EOI  3'h7

// reset values and cascade level
`define IC_MASK_RESET     8'h00
`define IC_LOWEST_RESET   3'h7
`define IC_SPURIOUS_LEVEL 3'h7
`define IC_EDGE_ARM       8'hff
`define IC_CASCADE_LEVEL  3'h2
`define IC_VBASE_PRI      5'h01
`define IC_VBASE_SEC      5'h0e

`endif

// ==== core/ic_pair.v ====
// Function
// [RQ1] after initialization all eight mask bits of each controller read zero
// [RQ2] mask bit n set masks level n, clear unmasks it; readable and writable
// [RQ3] odd port reads and non-init writes reach the mask register
// [RQ4] even port write with bits 4 and 3 zero is the rotate/eoi command
// [RQ5] codes 001, 011, 101 are eoi forms; 010 does nothing
// [RQ6] code 100 sets, 000 clears rotate-in-auto-eoi; auto eoi then rotates
// [RQ7] codes 111 and 110 act on the level in bits 2..0
// [RQ8] even port write with bit 3 set, bit 4 clear is poll/readsel command
// [RQ9] special mask flag loads from bit 5 only when bit 6 is set
// [RQ10] poll makes next read return active flag and highest requesting level
// [RQ11] a pending poll overrides the request/in-service read selection
// [RQ12] bit 1 set lets bit 0 choose request or in-service register readback
// [RQ13] a request input rising high sets its request bit
// [RQ14] interrupt output rises when an unmasked request outranks the serviced level
// [RQ15] first acknowledge freezes resolution, sets in-service and clears request; with ltim set the request bit keeps following the input
// [RQ16] data bus stays undriven during the first acknowledge
// [RQ17] cpu answers with two acknowledges and reads the vector on the second
// [RQ18] second acknowledge drives the eight-bit vector of the acknowledged level
// [RQ19] auto eoi clears in-service at the last acknowledge, else software eoi
// [RQ20] no request at first acknowledge gives level 7 vector, no in-service set
// [RQ21] vector bits 7..3 from programmed base, bits 2..0 the level number
// [RQ22] non-specific eoi clears highest in-service; specific clears named level
// [RQ23] nested mode holds off same and lower priority requests
// [RQ24] automatic rotation makes the serviced level lowest at its eoi
// [RQ25] secondary output feeds primary level 2 and supplies the cascaded vector
`include "ic_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module ic_unit #(
	parameter [4:0] VBASE_RESET = 5'h00
) (
	input  wire       clk,       // system clock
	input  wire       sys_rst,   // synchronous reset
	input  wire       wr,        // write strobe for this controller
	input  wire       rd,        // read strobe for this controller
	input  wire       a0,        // port address bit 0
	input  wire [7:0] wdata,     // write data
	input  wire [7:0] irq,       // request levels
	input  wire       ack1,      // first acknowledge pulse
	input  wire       ack2,      // second acknowledge pulse
	output reg  [7:0] rdata,     // read data for this cycle
	output reg        int_out,   // request toward cpu
	output reg        cur_found, // an eligible request exists
	output reg  [2:0] cur_level, // highest eligible level
	output wire [7:0] vector     // vector of the acknowledged level
);

	localparam [1:0] ST_RUN  = 2'h0;
	localparam [1:0] ST_VECTOR_BASE_WORD = 2'h1;
	localparam [1:0] ST_ICW3 = 2'h2;
	localparam [1:0] ST_ICW4 = 2'h3;
	reg [7:0] request_register;
	reg [7:0] in_service_register;
	reg [7:0] level_mask_register;
	reg [2:0] lowest;
	reg       rot_in_auto;
	reg       special_mask_flag;
	reg       poll_pend;
	reg       read_isr;
	reg [4:0] vector_base_word;
	reg       auto_end_of_interrupt;
	reg       ltim;
	reg       sngl;
	reg       ic4;
	reg [1:0] init_st;
	reg [7:0] irq_prev;
	reg [2:0] ack_level;
	reg [7:0] next_irr;
	reg [7:0] next_isr;
	reg [2:0] next_low;
	reg [7:0] isr_eff;
	reg       isr_found;
	reg [2:0] isr_level;
	reg [7:0] take_mask;
	reg       take;
	wire       icw1_wr = wr && !a0 && wdata[`IC_INIT_BIT];
	wire       cmd2_wr = wr && !a0 && !wdata[`IC_INIT_BIT] && !wdata[`IC_MASK_POLL_READSEL_COMMAND_BIT];
	wire       cmd3_wr = wr && !a0 && !wdata[`IC_INIT_BIT] && wdata[`IC_MASK_POLL_READSEL_COMMAND_BIT];
	wire [2:0] cmd     = wdata[7:5];
	wire [2:0] named   = wdata[2:0];
	// {found, level}: scan from just above the lowest-priority level
	function [3:0] ic_pick;
		input [7:0] vec;
		input [2:0] low;
		reg   [2:0] lvl;
		integer     k;
		begin
			ic_pick = 4'h0;
			for (k = 8; k >= 1; k = k - 1)
			begin
				lvl = low + k[2:0];
				if (vec[lvl])
					ic_pick = {1'b1, lvl};
			end
		end
	endfunction
	// 0 is the highest rank
	function [2:0] ic_rank;
		input [2:0] lvl;
		input [2:0] low;
		begin
			ic_rank = lvl - low - 3'h1;
		end
	endfunction
	assign vector = {vector_base_word, ack_level}; // RQ21
	always @*
	begin
		{cur_found, cur_level} = ic_pick(request_register & ~level_mask_register, lowest); // RQ2
		// masked in-service levels stop blocking in special mask mode
		isr_eff = special_mask_flag ? (in_service_register & ~level_mask_register) : in_service_register;
		{isr_found, isr_level} = ic_pick(isr_eff, lowest);
		int_out = cur_found &&
			(!isr_found || ic_rank(cur_level, lowest) < ic_rank(isr_level, lowest)); // RQ14 RQ23
		take = (ack1 || (rd && poll_pend)) && cur_found; // RQ15
		take_mask = {7'h00, take} << cur_level;
	end
	always @*
	begin
		next_isr = in_service_register;
		next_low = lowest;
		if (cmd2_wr) // RQ4
		begin
			case (cmd) // RQ5
				`IC_CMD_NS_EOI:
					if (isr_found)
						next_isr[isr_level] = 1'b0; // RQ22
				`IC_CMD_S_EOI:
					next_isr[named] = 1'b0; // RQ22
				`IC_CMD_ROT_NS_EOI:
				begin
					if (isr_found)
					begin
						next_isr[isr_level] = 1'b0;
						next_low = isr_level; // RQ24
					end
				end
				`IC_CMD_ROT_S_EOI:
				begin
					next_isr[named] = 1'b0; // RQ7
					next_low = named;
				end
				`IC_CMD_SET_PRI:
					next_low = named; // RQ7
				default:
					next_low = lowest;
			endcase
		end
		if (ack2 && auto_end_of_interrupt && isr_found) // RQ19
		begin
			next_isr[isr_level] = 1'b0;
			if (rot_in_auto)
				next_low = isr_level; // RQ6 RQ24
		end
		// setting wins over a clear in the same cycle
		next_isr = next_isr | take_mask; // RQ15
		next_irr = ltim ? irq : ((request_register & ~take_mask) | (irq & ~irq_prev)); // RQ13
	end
	always @*
	begin
		if (poll_pend)
			rdata = {cur_found, 4'h0, cur_level}; // RQ10 RQ11
		else if (a0)
			rdata = level_mask_register; // RQ3
		else if (read_isr)
			rdata = in_service_register; // RQ12
		else
			rdata = request_register;
	end

	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			request_register      <= 8'h00;
			in_service_register   <= 8'h00;
			level_mask_register   <= `IC_MASK_RESET;
			lowest                <= `IC_LOWEST_RESET;
			rot_in_auto           <= 1'b0;
			special_mask_flag     <= 1'b0;
			poll_pend             <= 1'b0;
			read_isr              <= 1'b0;
			vector_base_word      <= VBASE_RESET;
			auto_end_of_interrupt <= 1'b0;
			ltim                  <= 1'b0;
			sngl                  <= 1'b0;
			ic4                   <= 1'b0;
			init_st               <= ST_RUN;
			irq_prev              <= `IC_EDGE_ARM;
			ack_level             <= `IC_SPURIOUS_LEVEL;
		end
		else
		begin
			irq_prev            <= irq;
			request_register    <= next_irr;
			in_service_register <= next_isr;
			lowest              <= next_low;
			if (ack1)
				ack_level <= cur_found ? cur_level : `IC_SPURIOUS_LEVEL; // RQ20
			if (rd && poll_pend)
				poll_pend <= 1'b0;
			if (icw1_wr)
			begin
				// new edges only: arm every level as already high
				request_register      <= 8'h00;
				irq_prev              <= `IC_EDGE_ARM;
				level_mask_register   <= `IC_MASK_RESET; // RQ1
				lowest                <= `IC_LOWEST_RESET;
				special_mask_flag     <= 1'b0;
				read_isr              <= 1'b0;
				poll_pend             <= 1'b0;
				auto_end_of_interrupt <= 1'b0;
				ltim                  <= wdata[`IC_LTIM_BIT];
				sngl                  <= wdata[`IC_SNGL_BIT];
				ic4                   <= wdata[`IC_IC4_BIT];
				init_st               <= ST_VECTOR_BASE_WORD;
			end
			else if (wr && a0 && init_st != ST_RUN)
			begin
				case (init_st)
					ST_VECTOR_BASE_WORD:
					begin
						vector_base_word <= wdata[7:3]; // RQ21
						init_st          <= !sngl ? ST_ICW3 : (ic4 ? ST_ICW4 : ST_RUN);
					end
					ST_ICW3:
						init_st <= ic4 ? ST_ICW4 : ST_RUN;
					default:
					begin
						auto_end_of_interrupt <= wdata[`IC_AUTO_END_OF_INTERRUPT_BIT];
						init_st               <= ST_RUN;
					end
				endcase
			end
			else if (wr && a0)
				level_mask_register <= wdata; // RQ2 RQ3
			else if (cmd2_wr && (cmd == `IC_CMD_ROT_SET || cmd == `IC_CMD_ROT_CLR))
				rot_in_auto <= (cmd == `IC_CMD_ROT_SET); // RQ6
			else if (cmd3_wr) // RQ8
			begin
				if (wdata[`IC_SPECIAL_MASK_WRITE_ENABLE_BIT])
					special_mask_flag <= wdata[`IC_SMM_BIT]; // RQ9
				if (wdata[`IC_POLL_BIT])
					poll_pend <= 1'b1; // RQ10
				if (wdata[`IC_RR_BIT])
					read_isr <= wdata[`IC_RIS_BIT]; // RQ12
			end
		end
	end
endmodule // ic_unit

module ic_pair #(
	parameter [4:0] PRI_VBASE = `IC_VBASE_PRI,
	parameter [4:0] SEC_VBASE = `IC_VBASE_SEC
) (
	input  wire        clk,                    // system clock, 100 MHz
	input  wire        sys_rst,                // synchronous reset, active high
	input  wire [15:0] io_addr,                // i/o port address
	input  wire        io_wr,                  // i/o write strobe, one cycle
	input  wire        io_rd,                  // i/o read strobe, one cycle
	input  wire [7:0]  io_wdata,               // i/o write data
	input  wire        interrupt_acknowledge,  // acknowledge cycle strobe, one cycle
	input  wire [15:0] irq_pin,                // request pins, level 2 unused
	output reg  [7:0]  io_rdata,               // read or vector data
	output reg         io_rdata_oe,            // data bus drive enable
	output reg         cpu_interrupt_output    // interrupt request to cpu
);

	wire [15:0] irq_s;
	wire        pri_sel = (io_addr[15:5] == `IC_PRI_BLOCK);
	wire        sec_sel = (io_addr[15:5] == `IC_SEC_BLOCK);
	wire [7:0]  pri_rdata;
	wire [7:0]  sec_rdata;
	wire [7:0]  pri_vec;
	wire [7:0]  sec_vec;
	wire        pri_int;
	wire        sec_int;
	wire        pri_found;
	wire [2:0]  pri_level;
	reg         ack_second;
	reg         ack_casc;

	wire pri_ack1 = interrupt_acknowledge && !ack_second;
	wire sec_ack1 = pri_ack1 && pri_found && pri_level == `IC_CASCADE_LEVEL; // RQ25
	wire pri_ack2 = interrupt_acknowledge && ack_second;
	wire sec_ack2 = pri_ack2 && ack_casc;
	ic_sync u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.pin     (irq_pin),
		.level   (irq_s)
	);
	ic_unit #(
		.VBASE_RESET (PRI_VBASE)
	) u_primary (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.wr        (io_wr && pri_sel),
		.rd        (io_rd && pri_sel),
		.a0        (io_addr[0]),
		.wdata     (io_wdata),
		.irq       ({irq_s[7:3], sec_int, irq_s[1:0]}), // RQ25
		.ack1      (pri_ack1),
		.ack2      (pri_ack2),
		.rdata     (pri_rdata),
		.int_out   (pri_int),
		.cur_found (pri_found),
		.cur_level (pri_level),
		.vector    (pri_vec)
	);
	ic_unit #(
		.VBASE_RESET (SEC_VBASE)
	) u_secondary (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.wr        (io_wr && sec_sel),
		.rd        (io_rd && sec_sel),
		.a0        (io_addr[0]),
		.wdata     (io_wdata),
		.irq       (irq_s[15:8]),
		.ack1      (sec_ack1),
		.ack2      (sec_ack2),
		.rdata     (sec_rdata),
		.int_out   (sec_int),
		.cur_found (),
		.cur_level (),
		.vector    (sec_vec)
	);
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			ack_second           <= 1'b0;
			ack_casc             <= 1'b0;
			io_rdata             <= 8'h00;
			io_rdata_oe          <= 1'b0;
			cpu_interrupt_output <= 1'b0;
		end
		else
		begin
			cpu_interrupt_output <= pri_int; // RQ14
			io_rdata_oe          <= 1'b0;
			if (interrupt_acknowledge) // RQ17
			begin
				if (!ack_second)
				begin
					ack_second <= 1'b1; // RQ16
					ack_casc   <= sec_ack1;
				end
				else
				begin
					ack_second  <= 1'b0;
					io_rdata    <= ack_casc ? sec_vec : pri_vec; // RQ18 RQ25
					io_rdata_oe <= 1'b1;
				end
			end
			else if (io_rd && (pri_sel || sec_sel))
			begin
				io_rdata    <= pri_sel ? pri_rdata : sec_rdata;
				io_rdata_oe <= 1'b1;
			end
		end
	end
endmodule // ic_pair

`default_nettype wire

// ==== core/ic_sync.v ====
`timescale 1ns/1ps
`default_nettype none

module ic_sync #(
	parameter WIDTH = 16
) (
	input  wire             clk,     // system clock
	input  wire             sys_rst, // synchronous reset
	input  wire [WIDTH-1:0] pin,     // asynchronous levels
	output reg  [WIDTH-1:0] level    // filtered levels
);

	reg [WIDTH-1:0] stage1;
	reg [WIDTH-1:0] stage2;
	reg [WIDTH-1:0] stage3;
	integer         i;

	// a change counts once stages two and three agree
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			stage1 <= {WIDTH{1'b0}};
			stage2 <= {WIDTH{1'b0}};
			stage3 <= {WIDTH{1'b0}};
			level  <= {WIDTH{1'b0}};
		end
		else
		begin
			stage1 <= pin;
			stage2 <= stage1;
			stage3 <= stage2;
			for (i = 0; i < WIDTH; i = i + 1)
				if (stage2[i] == stage3[i])
					level[i] <= stage3[i];
		end
	end

endmodule // ic_sync

`default_nettype wire

// ==== testbench/ic_cpu.sv ====
`timescale 1ns/1ps
`default_nettype none
module ic_cpu (
	input  wire logic        clk,                  // clock
	input  wire logic [7:0]  io_rdata,             // read data
	input  wire logic        io_rdata_oe,          // drive enable
	output var  logic [15:0] io_addr,              // port address
	output var  logic        io_wr,                // write strobe
	output var  logic        io_rd,                // read strobe
	output var  logic [7:0]  io_wdata,             // write data
	output var  logic        interrupt_acknowledge // acknowledge
);
	initial
	begin
		io_addr = 16'hffff;
		io_wr = 1'h0;
		io_rd = 1'h0;
		io_wdata = 8'h00;
		interrupt_acknowledge = 1'h0;
	end
	task automatic bus(input logic [15:0] a, input logic [7:0] d, input logic w);
		@(negedge clk);
		io_addr = a;
		io_wdata = d;
		io_wr = w;
		io_rd = !w;
		@(negedge clk);
		io_wr = 1'h0;
		io_rd = 1'h0;
		io_addr = ~a;
		io_wdata = ~d;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		bus(a, d, 1'h1);
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		bus(a, 8'h00, 1'h0);
		d = (io_rdata_oe === 1'h1) ? io_rdata : 8'hxx;
	endtask
	// two acknowledges, vector taken after the second
	task automatic ack(input int gap, output logic [7:0] d);
		@(negedge clk);
		interrupt_acknowledge = 1'h1;
		@(negedge clk);
		if (gap > 0)
		begin
			interrupt_acknowledge = 1'h0;
			repeat (gap) @(negedge clk);
			interrupt_acknowledge = 1'h1;
		end
		@(negedge clk);
		interrupt_acknowledge = 1'h0;
		d = (io_rdata_oe === 1'h1) ? io_rdata : 8'hxx;
	endtask
endmodule // ic_cpu
`default_nettype wire

// ==== testbench/ic_pair_assertions.sv ====
`include "ic_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module ic_pair_chk #(
	parameter [4:0] PRI_VBASE = `IC_VBASE_PRI,
	parameter [4:0] SEC_VBASE = `IC_VBASE_SEC
) (
	input wire logic        clk,                   // clock
	input wire logic        sys_rst,               // reset
	input wire logic [15:0] io_addr,               // port address
	input wire logic        io_wr,                 // write strobe
	input wire logic        io_rd,                 // read strobe
	input wire logic [7:0]  io_wdata,              // write data
	input wire logic        interrupt_acknowledge, // acknowledge
	input wire logic [15:0] irq_pin,               // request pins
	input wire logic [7:0]  io_rdata,              // read data
	input wire logic        io_rdata_oe,           // drive enable
	input wire logic        cpu_interrupt_output   // cpu request
);
	logic       ack_second; // next acknowledge carries the vector
	logic       seen_req;   // a pin went high since reset
	logic [1:0] poll_pend;  // poll pending per controller
	wire        in_rng = io_addr[15:5] == `IC_PRI_BLOCK || io_addr[15:5] == `IC_SEC_BLOCK;
	wire        rd_hit = io_rd && in_rng && !interrupt_acknowledge;
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			ack_second <= 1'h0;
			seen_req   <= 1'h0;
			poll_pend  <= 2'h0;
		end
		else
		begin
			ack_second <= ack_second ^ interrupt_acknowledge;
			seen_req   <= seen_req || irq_pin != 16'h0000;
			if (io_wr && in_rng && !io_addr[0] && io_wdata[4:3] == 2'h1)
				poll_pend[io_addr[7]] <= io_wdata[2];
			else if (rd_hit)
				poll_pend[io_addr[7]] <= 1'h0;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	sequence s_ack1;
		interrupt_acknowledge && !ack_second;
	endsequence
	sequence s_ack2;
		interrupt_acknowledge && ack_second;
	endsequence
	property p_read_answer;
		rd_hit |=> io_rdata_oe;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read not answered");
	property p_stray_read;
		io_rd && !in_rng && !interrupt_acknowledge |=> !io_rdata_oe;
	endproperty
	a_stray_read: assert property (p_stray_read) else $error("foreign read answered");
	property p_ack1_quiet;
		s_ack1 |=> !io_rdata_oe;
	endproperty
	a_ack1_quiet: assert property (p_ack1_quiet) else $error("bus driven on first acknowledge");
	property p_ack2_vec;
		s_ack2 |=> io_rdata_oe && (io_rdata[7:3] == PRI_VBASE || io_rdata[7:3] == SEC_VBASE);
	endproperty
	a_ack2_vec: assert property (p_ack2_vec) else $error("bad vector cycle");
	property p_oe_cause;
		io_rdata_oe |-> $past(io_rd) || $past(interrupt_acknowledge);
	endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("bus driven without cause");
	property p_poll_byte;
		poll_pend[io_addr[7]] && rd_hit |=> io_rdata[6:3] == 4'h0;
	endproperty
	a_poll_byte: assert property (p_poll_byte) else $error("poll byte malformed");
	property p_reset_quiet;
		$fell(sys_rst) |-> !io_rdata_oe && !cpu_interrupt_output;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
	property p_int_cause;
		!seen_req |-> !cpu_interrupt_output;
	endproperty
	a_int_cause: assert property (p_int_cause) else $error("request without pin");
endmodule // ic_pair_chk
bind ic_pair ic_pair_chk #(.PRI_VBASE(PRI_VBASE), .SEC_VBASE(SEC_VBASE)) u_chk (.clk(clk), .sys_rst(sys_rst),
	.io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
	.interrupt_acknowledge(interrupt_acknowledge), .irq_pin(irq_pin), .io_rdata(io_rdata),
	.io_rdata_oe(io_rdata_oe), .cpu_interrupt_output(cpu_interrupt_output));
`default_nettype wire

// ==== testbench/ic_pair_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module ic_pair_tb;
	logic        clk;
	logic        sys_rst;
	logic [15:0] io_addr;
	logic        io_wr;
	logic        io_rd;
	logic [7:0]  io_wdata;
	logic        interrupt_acknowledge;
	logic [15:0] irq_pin;
	logic [7:0]  io_rdata;
	logic        io_rdata_oe;
	logic        cpu_interrupt_output;
	logic [7:0]  v;
	logic [31:0] rows [8];
	int          n_mismatch = 0;
	int          checks_done = 0;
	int          cyc = 0;
	ic_pair uut (.clk(clk), .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
		.io_wdata(io_wdata), .interrupt_acknowledge(interrupt_acknowledge), .irq_pin(irq_pin),
		.io_rdata(io_rdata), .io_rdata_oe(io_rdata_oe), .cpu_interrupt_output(cpu_interrupt_output));
	ic_cpu cpu (.clk(clk), .io_rdata(io_rdata), .io_rdata_oe(io_rdata_oe), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .interrupt_acknowledge(interrupt_acknowledge));
	initial
	begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc = cyc + 1;
		if (cyc == 5000)
		begin
			n_mismatch = n_mismatch + 1;
			report_and_stop();
		end
	end
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp)
		begin
			n_mismatch = n_mismatch + 1;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic w(input logic [7:0] a, input logic [7:0] d);
		cpu.wr({8'h00, a}, d);
	endtask
	task automatic r(input logic [7:0] a, input logic [7:0] e);
		cpu.rd({8'h00, a}, v);
		check("rdata", v, e);
	endtask
	task automatic k(input int gap, input logic [7:0] e);
		cpu.ack(gap, v);
		check("vector", v, e);
	endtask
	task automatic it(input logic e);
		wt(8);
		check("int", {7'h00, cpu_interrupt_output}, {7'h00, e});
	endtask
	initial
	begin
		sys_rst = 1'h1;
		irq_pin = 16'h0000;
		rows = '{32'h21a5_21a5, 32'ha13c_a13c, 32'h235a_215a, 32'h2100_2100,
			32'ha100_bf00, 32'ha00b_a000, 32'h2040_2000, 32'h200a_2000};
		wt(2);
		sys_rst = 1'h0;
		r(8'h21, 8'h00);
		r(8'ha1, 8'h00);
		foreach (rows[i])
		begin
			w(rows[i][31:24], rows[i][23:16]);
			r(rows[i][15:8], rows[i][7:0]);
		end
		cpu.rd(16'h0040, v);
		check("unmapped", v, 8'hxx);
		irq_pin = 16'h0008;
		it(1'h1);
		r(8'h20, 8'h08);
		k(2, 8'h0b);
		r(8'h20, 8'h00);
		w(8'h20, 8'h0b);
		r(8'h20, 8'h08);
		irq_pin = 16'h0028;
		it(1'h0);
		irq_pin = 16'h002a;
		it(1'h1);
		k(0, 8'h09);
		w(8'h20, 8'h40);
		r(8'h20, 8'h0a);
		w(8'h20, 8'h20);
		r(8'h20, 8'h08);
		it(1'h0);
		w(8'h20, 8'h63);
		it(1'h1);
		k(1, 8'h0d);
		irq_pin = 16'h002b;
		wt(6);
		w(8'h20, 8'h0c);
		r(8'h20, 8'h80);
		r(8'h20, 8'h21);
		w(8'h20, 8'h20);
		w(8'h20, 8'h20);
		r(8'h20, 8'h00);
		irq_pin = 16'h0200;
		it(1'h1);
		k(1, 8'h71);
		r(8'ha0, 8'h02);
		w(8'ha0, 8'h20);
		w(8'h20, 8'h20);
		irq_pin = 16'h0000;
		w(8'h21, 8'h10);
		irq_pin = 16'h0010;
		it(1'h0);
		w(8'h21, 8'h00);
		it(1'h1);
		k(1, 8'h0c);
		w(8'h21, 8'h10);
		w(8'h20, 8'h68);
		w(8'h20, 8'h08);
		irq_pin = 16'h0050;
		it(1'h1);
		w(8'h20, 8'h48);
		it(1'h0);
		w(8'h21, 8'h00);
		w(8'h20, 8'he4);
		it(1'h1);
		k(1, 8'h0e);
		w(8'h20, 8'h20);
		irq_pin = 16'h0000;
		wt(3);
		irq_pin = 16'h0021;
		it(1'h1);
		k(1, 8'h0d);
		w(8'h20, 8'ha0);
		irq_pin = 16'h0001;
		wt(3);
		irq_pin = 16'h0021;
		k(1, 8'h08);
		w(8'h20, 8'h20);
		w(8'h20, 8'hc0);
		irq_pin = 16'h0020;
		wt(3);
		irq_pin = 16'h0021;
		it(1'h1);
		k(1, 8'h0d);
		w(8'h20, 8'h20);
		w(8'h21, 8'h01);
		k(1, 8'h0f);
		r(8'h20, 8'h00);
		irq_pin = 16'h0000;
		w(8'h20, 8'h11);
		w(8'h21, 8'h08);
		w(8'h21, 8'h04);
		w(8'h21, 8'h03);
		r(8'h21, 8'h00);
		w(8'h20, 8'h80);
		irq_pin = 16'h0011;
		it(1'h1);
		k(1, 8'h08);
		w(8'h20, 8'h0b);
		r(8'h20, 8'h00);
		irq_pin = 16'h0010;
		wt(3);
		irq_pin = 16'h0011;
		it(1'h1);
		k(1, 8'h0c);
		w(8'h20, 8'h00);
		k(1, 8'h08);
		irq_pin = 16'h0059;
		it(1'h1);
		k(1, 8'h0e);
		report_and_stop();
	end
endmodule // ic_pair_tb
`default_nettype wire
